// ==== design/mms_pkg.sv ====
// constants for the monitor selection and scratch register bank
// assumes a 16-bit command frame: 2 control, 5 address, parity, 8 data
package mms_pkg;

  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned HEADER_BITS   = 8;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned SCRATCH_DEPTH = 4;

  // control field of the frame
  localparam logic [1:0] CTRL_READ  = 2'h0;
  localparam logic [1:0] CTRL_WRITE = 2'h1;

  // register addresses
  localparam logic [4:0] ADDR_MONITOR   = 5'h00;
  localparam logic [4:0] ADDR_SCRATCH_A = 5'h01;
  localparam logic [4:0] ADDR_SCRATCH_B = 5'h02;
  localparam logic [4:0] ADDR_SCRATCH_C = 5'h03;
  localparam logic [4:0] ADDR_SCRATCH_D = 5'h04;

  // monitor selection register layout
  localparam int unsigned SEL_MSB     = 7;
  localparam int unsigned SEL_LSB     = 5;
  localparam int unsigned RES_EN_BIT  = 4;
  localparam int unsigned IO_ATT_BIT  = 3;
  localparam logic [7:0]  MON_WR_MASK = 8'hf8;

  // reset values
  localparam logic [7:0] MON_RESET     = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;

  // selection codes
  localparam logic [2:0] SEL_OFF     = 3'h0;
  localparam logic [2:0] SEL_CURRENT = 3'h1;
  localparam logic [2:0] SEL_VREF    = 3'h2;
  localparam logic [2:0] SEL_TEMP    = 3'h3;
  localparam logic [2:0] SEL_IO0     = 3'h4;
  localparam logic [2:0] SEL_IO1     = 3'h5;
  localparam logic [2:0] SEL_SUPPLY  = 3'h6;
  localparam logic [2:0] SEL_SENSE   = 3'h7;

  // frame sequencer, gray coded
  typedef enum logic [1:0] {
    MMS_IDLE   = 2'b00,
    MMS_FRAME  = 2'b01,
    MMS_COMMIT = 2'b11
  } mms_state_e;

endpackage

// ==== design/mms_scratch_mem.sv ====
// four-entry scratch byte store with registered read data
// assumes srst is the power-on reset, nothing else clears the entries
`timescale 1ns/1ps
`default_nettype none
module mms_scratch_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4,
  parameter int unsigned AW    = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  import mms_pkg::*;

  logic [WIDTH-1:0] entry [DEPTH];

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        entry[i] <= WIDTH'(SCRATCH_RESET); // RULE_09
      end else if (wr_en && wr_addr == AW'(i)) begin
        entry[i] <= wr_data; // RULE_08
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data <= WIDTH'(SCRATCH_RESET);
    end else begin
      rd_data <= entry[rd_addr]; // RULE_08
    end
  end
endmodule
`default_nettype wire

// ==== design/mms_regs.sv ====
// monitor selection register and scratch bytes behind the serial frame port
// assumes sclk half period spans at least four sys_clk cycles; pins are asynchronous
//
// What this block does
// RULE_01: host writes monitor select at address zero
// RULE_02: bits 7..5 pick monitor source, 000 off
// RULE_03: code 001 routes regulator current to resistor
// RULE_04: bit 4 connects internal sense resistor
// RULE_05: bit 3 gain/attenuation, only for 100/101
// RULE_06: monitor cleared on reset, regulator off, non-normal
// RULE_07: regulator off: monitor access ignored, cleared
// RULE_08: four scratch bytes at addresses one to four
// RULE_09: scratch bytes cleared only by power-on reset
// RULE_10: parity bit makes total ones count odd
// RULE_11: parity disabled means host sends bit 8 zero
// RULE_12: monitor bits 2..0 ignored, read as zero
`timescale 1ns/1ps
`default_nettype none
module mms_regs (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe_n,
  input  wire logic [7:0] fixed_status,
  input  wire logic       parity_enable,
  input  wire logic       transceiver_supply_regulator,
  input  wire logic       normal_mode,
  output logic [2:0]      monitor_select,
  output logic            monitor_enable,
  output logic            internal_sense_resistor_enable,
  output logic            current_sense_internal,
  output logic            current_sense_external,
  output logic            io_attenuate
);
  import mms_pkg::*;

  logic       sclk_m, sclk_s, sclk_p;
  logic       cs_n_m, cs_n_s, cs_n_p;
  logic       mosi_m, mosi_s;
  mms_state_e state;
  logic [4:0] bit_cnt;
  logic [15:0] rx;
  logic [15:0] tx;
  logic [7:0] mon;
  logic [7:0] mem_rd_data;
  logic       mem_wr_en;
  logic [1:0] mem_wr_addr;
  logic [7:0] mem_wr_data;
  logic       sclk_rise, sclk_fall, frame_start, frame_end;
  logic       mon_open;
  logic [1:0] hdr_ctrl;
  logic [4:0] hdr_addr;
  logic [1:0] scratch_idx;
  logic       hdr_scratch;
  logic [7:0] read_byte;
  logic       parity_ok;
  logic       commit_wr;

  // two-stage synchronisers on the pins, third stage only for edge detection
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_p <= 1'b0;
      cs_n_m <= 1'b1;
      cs_n_s <= 1'b1;
      cs_n_p <= 1'b1;
      mosi_m <= 1'b0;
      mosi_s <= 1'b0;
    end else begin
      sclk_m <= sclk;
      sclk_s <= sclk_m;
      sclk_p <= sclk_s;
      cs_n_m <= cs_n;
      cs_n_s <= cs_n_m;
      cs_n_p <= cs_n_s;
      mosi_m <= mosi;
      mosi_s <= mosi_m;
    end
  end

  assign sclk_rise   = sclk_s & ~sclk_p;
  assign sclk_fall   = ~sclk_s & sclk_p;
  assign frame_start = ~cs_n_s & cs_n_p;
  assign frame_end   = cs_n_s & ~cs_n_p;
  assign mon_open    = transceiver_supply_regulator & normal_mode;

  // header lies in rx[7:0] once eight bits are in, whole frame in rx[15:0] at the end
  assign hdr_ctrl    = (state == MMS_COMMIT) ? rx[15:14] : rx[7:6];
  assign hdr_addr    = (state == MMS_COMMIT) ? rx[13:9] : rx[5:1];
  assign hdr_scratch = (hdr_addr >= ADDR_SCRATCH_A) && (hdr_addr <= ADDR_SCRATCH_D);
  assign scratch_idx = 2'(hdr_addr - ADDR_SCRATCH_A);
  assign parity_ok   = ~parity_enable | (^rx); // RULE_10
  assign commit_wr   = (state == MMS_COMMIT) && (hdr_ctrl == CTRL_WRITE) && parity_ok;

  always_comb begin
    read_byte = 8'h00;
    if (hdr_addr == ADDR_MONITOR) begin
      read_byte = mon_open ? (mon & MON_WR_MASK) : 8'h00; // RULE_07
    end else if (hdr_scratch) begin
      read_byte = mem_rd_data; // RULE_08
    end
  end

  // frame sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= MMS_IDLE;
    end else begin
      unique case (state)
        MMS_IDLE: begin
          if (frame_start) begin
            state <= MMS_FRAME;
          end
        end
        MMS_FRAME: begin
          if (frame_end) begin
            state <= (bit_cnt == 5'(FRAME_BITS)) ? MMS_COMMIT : MMS_IDLE;
          end
        end
        MMS_COMMIT: begin
          state <= MMS_IDLE;
        end
        default: begin
          state <= MMS_IDLE;
        end
      endcase
    end
  end

  // receive shifter, sampled on rising sclk
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx      <= 16'h0000;
      bit_cnt <= 5'h00;
    end else if (frame_start) begin
      rx      <= 16'h0000;
      bit_cnt <= 5'h00;
    end else if (state == MMS_FRAME && sclk_rise && bit_cnt < 5'(FRAME_BITS)) begin
      rx      <= {rx[14:0], mosi_s};
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // transmit shifter, advanced on falling sclk; data byte loaded after the header
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx <= 16'h0000;
    end else if (frame_start) begin
      tx <= {fixed_status, 8'h00};
    end else if (state == MMS_FRAME && sclk_fall) begin
      if (bit_cnt == 5'(HEADER_BITS)) begin
        tx <= {read_byte, 8'h00};
      end else begin
        tx <= {tx[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      miso      <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso      <= tx[15];
      miso_oe_n <= cs_n_s | (state == MMS_IDLE);
    end
  end

  // monitor selection register
  always_ff @(posedge sys_clk) begin
    if (srst || !mon_open) begin
      mon <= MON_RESET; // RULE_06 RULE_07
    end else if (commit_wr && hdr_addr == ADDR_MONITOR) begin
      mon <= rx[7:0] & MON_WR_MASK; // RULE_01 RULE_12
    end
  end

  // scratch store write port
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mem_wr_en   <= 1'b0;
      mem_wr_addr <= 2'h0;
      mem_wr_data <= 8'h00;
    end else begin
      mem_wr_en   <= commit_wr && hdr_scratch; // RULE_08
      mem_wr_addr <= scratch_idx;
      mem_wr_data <= rx[7:0];
    end
  end

  mms_scratch_mem #(
    .WIDTH (DATA_BITS),
    .DEPTH (SCRATCH_DEPTH),
    .AW    (2)
  ) u_scratch (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_addr (scratch_idx),
    .rd_data (mem_rd_data)
  );

  // decoded monitor controls
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      monitor_select                 <= SEL_OFF;
      monitor_enable                 <= 1'b0;
      internal_sense_resistor_enable <= 1'b0;
      current_sense_internal         <= 1'b0;
      current_sense_external         <= 1'b0;
      io_attenuate                   <= 1'b0;
    end else begin
      monitor_select <= mon[SEL_MSB:SEL_LSB]; // RULE_02
      monitor_enable <= mon[SEL_MSB:SEL_LSB] != SEL_OFF; // RULE_02
      internal_sense_resistor_enable <= mon[RES_EN_BIT]; // RULE_04
      current_sense_internal <= (mon[SEL_MSB:SEL_LSB] == SEL_CURRENT) & mon[RES_EN_BIT]; // RULE_03
      current_sense_external <= (mon[SEL_MSB:SEL_LSB] == SEL_CURRENT) & ~mon[RES_EN_BIT]; // RULE_03
      io_attenuate <= mon[IO_ATT_BIT] & ((mon[SEL_MSB:SEL_LSB] == SEL_IO0) |
                                         (mon[SEL_MSB:SEL_LSB] == SEL_IO1)); // RULE_05
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_mon_write;
    commit_wr && hdr_addr == ADDR_MONITOR && mon_open;
  endsequence

  sequence s_mon_locked;
    !transceiver_supply_regulator;
  endsequence

  sequence s_bad_parity;
    state == MMS_COMMIT && hdr_ctrl == CTRL_WRITE && parity_enable && !(^rx);
  endsequence

  sequence s_mon_closed;
    !mon_open;
  endsequence

  sequence s_good_write;
    state == MMS_COMMIT && hdr_ctrl == CTRL_WRITE && (!parity_enable || (^rx));
  endsequence

  sequence s_data_load;
    state == MMS_FRAME && sclk_fall && bit_cnt == 5'h08;
  endsequence

  AST_MON_WRITE: assert property (s_mon_write |=> mon == ($past(rx[7:0]) & 8'hf8)) // RULE_01
    else $error("monitor register did not take written byte");
  AST_SELECT_OUT: assert property (s_mon_write |=> ##1 // RULE_02
      monitor_select == $past(rx[7:5], 2) && monitor_enable == ($past(rx[7:5], 2) != 3'h0))
    else $error("selection outputs do not follow register");
  AST_CURRENT_ROUTE: assert property (current_sense_internal |-> // RULE_03
      monitor_select == 3'h1 && internal_sense_resistor_enable && !current_sense_external)
    else $error("current copy routing wrong");
  AST_RES_EN: assert property (!$past(srst) |-> // RULE_04
      internal_sense_resistor_enable == $past(mon[4]))
    else $error("resistor enable does not follow bit 4");
  AST_ATT_GATE: assert property (io_attenuate |-> // RULE_05
      (monitor_select == 3'h4 || monitor_select == 3'h5) && $past(mon[3]))
    else $error("attenuation active outside io selections");
  AST_MODE_CLEAR: assert property (!normal_mode |=> mon == 8'h00 ##1 monitor_select == 3'h0) // RULE_06
    else $error("monitor register not cleared outside normal mode");
  AST_REG_OFF: assert property (s_mon_locked ##1 s_mon_locked |-> // RULE_07
      mon == 8'h00 && !mem_wr_en || mon == 8'h00)
    else $error("monitor register kept while regulator off");
  AST_READ_OFF: assert property (state == MMS_FRAME && sclk_fall && // RULE_07
      bit_cnt == 5'h08 && hdr_addr == 5'h00 && !mon_open |=> tx[15:8] == 8'h00)
    else $error("monitor read while blocked returned data");
  AST_SCRATCH_WR: assert property (commit_wr && hdr_scratch |=> // RULE_08
      mem_wr_en && mem_wr_data == $past(rx[7:0]) && mem_wr_addr == $past(rx[10:9]) - 2'h1)
    else $error("scratch write not issued");
  AST_PARITY_BLOCK: assert property (s_bad_parity |=> !mem_wr_en && $stable(mon) || mon == 8'h00) // RULE_10
    else $error("write with bad parity was accepted");
  AST_LOW_ZERO: assert property (s_mon_write ##1 1'b1 [*3] |-> mon[2:0] == 3'h0) // RULE_12
    else $error("monitor low bits not zero");
  AST_OUT_CLEAR: assert property (s_mon_closed ##1 s_mon_closed |=> !monitor_enable && // RULE_06
      monitor_select == 3'h0 && !internal_sense_resistor_enable && !io_attenuate)
    else $error("monitor outputs not cleared while access blocked");
  AST_EXT_ROUTE: assert property (current_sense_external |-> // RULE_03
      monitor_select == 3'h1 && !internal_sense_resistor_enable && !current_sense_internal)
    else $error("external current routing wrong");
  AST_ENABLE_CODE: assert property (monitor_enable == (monitor_select != 3'h0)) // RULE_02
    else $error("monitor enable disagrees with selection code");
  AST_MON_READ: assert property (s_data_load ##0 hdr_addr == 5'h00 |=> tx[10:8] == 3'h0) // RULE_12
    else $error("monitor read-back low bits not zero");
  AST_GOOD_WRITE: assert property (s_good_write ##0 hdr_scratch |=> mem_wr_en) // RULE_10
    else $error("write with good parity was dropped");
  AST_SHORT_FRAME: assert property (state == MMS_FRAME && frame_end && bit_cnt != 5'h10 |=> // RULE_01
      state == MMS_IDLE ##1 !mem_wr_en)
    else $error("frame of wrong length was acted upon");
  AST_WR_ORIGIN: assert property (mem_wr_en |-> $past(commit_wr && hdr_scratch)) // RULE_09
    else $error("scratch written without a write frame");
  AST_OE_IDLE: assert property ($past(state == MMS_IDLE) |-> miso_oe_n) // RULE_08
    else $error("serial output driven outside a frame");
  AST_OE_FRAME: assert property ($past(state == MMS_FRAME && !cs_n_s) |-> !miso_oe_n) // RULE_08
    else $error("serial output not driven inside a frame");
endmodule
`default_nettype wire

// ==== testbench/mms_host.sv ====
// serial host model: sends the first nclk bits of a 16-bit frame msb first, clock idle low, sample on rise
// assumes sys_clk at 10 MHz; sclk half period is five sys_clk cycles
`timescale 1ns/1ps
`default_nettype none
module mms_host (
  input  wire logic        sys_clk,
  input  wire logic        start,
  input  wire logic [15:0] frame,
  input  wire logic [4:0]  nclk,
  input  wire logic        miso,
  output logic             sclk,
  output logic             cs_n,
  output logic             mosi,
  output logic             done,
  output logic [15:0]      rx
);
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    done = 1'b0;
    rx   = 16'h0000;
    forever begin
      @(posedge sys_clk);
      if (start) begin
        cs_n <= 1'b0;
        wt(6);
        for (int i = 15; i >= 0; i--) begin
          if (15 - i < int'(nclk)) begin
            mosi <= frame[i];
            wt(5);
            sclk <= 1'b1;
            rx[i] <= miso;
            wt(5);
            sclk <= 1'b0;
          end
        end
        wt(5);
        cs_n <= 1'b1;
        // released line must not keep showing the last bit
        mosi <= ~mosi;
        done <= 1'b1;
        wt(1);
        done <= 1'b0;
        wt(5);
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/mms_regs_bench.sv ====
// self-checking bench for the monitor select and scratch register bank
// assumes the host model in mms_host.sv and constants of mms_pkg
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module mms_regs_bench;
  import mms_pkg::*;
  logic        sys_clk = 1'b0, srst = 1'b1, start = 1'b0, pe = 1'b0, reg_on = 1'b1;
  logic        nrm = 1'b1, miso, miso_oe_n, sclk, cs_n, mosi, done;
  logic        sens_int, sens_ext, io_att, mon_en, res_en;
  logic [2:0]  sel;
  logic [15:0] frame = 16'h0000, rx;
  logic [4:0]  nclk = 5'h10;
  logic [7:0]  stat = 8'h00, mon, d;
  logic [7:0]  scr[4];
  int          bad_count = 0, total_checks = 0;

  always #50 sys_clk = ~sys_clk;

  mms_host mms_host_i (.sys_clk(sys_clk), .start(start), .frame(frame), .nclk(nclk),
    .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .done(done), .rx(rx));
  mms_regs mms_regs_i (.sys_clk(sys_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n), .fixed_status(stat),
    .parity_enable(pe), .transceiver_supply_regulator(reg_on), .normal_mode(nrm),
    .monitor_select(sel), .monitor_enable(mon_en), .internal_sense_resistor_enable(res_en),
    .current_sense_internal(sens_int), .current_sense_external(sens_ext),
    .io_attenuate(io_att));

  function automatic logic [15:0] mk(logic [1:0] c, logic [4:0] a, logic [7:0] v);
    logic [15:0] f;
    f = {c, a, 1'b0, v};
    f[8] = pe & ~(^f);
    return f;
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic setc(logic p, logic r, logic n);
    pe <= p;
    reg_on <= r;
    nrm <= n;
    if (!r || !n) mon = 8'h00;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic xfer(logic [15:0] f, int n);
    int k;
    frame <= f;
    nclk <= n[4:0];
    stat <= 8'($urandom);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 400) begin
      @(posedge sys_clk);
      k++;
      if (k == 10) `CHK(miso_oe_n, 1'b0)
    end
    if (k >= 400) bad_count++;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic wr(logic [4:0] a, logic [7:0] v);
    xfer(mk(CTRL_WRITE, a, v), 16);
    if (a == ADDR_MONITOR && reg_on && nrm) mon = v & MON_WR_MASK;
    else if (a >= ADDR_SCRATCH_A && a <= ADDR_SCRATCH_D) scr[a - 1] = v;
  endtask

  task automatic rd(logic [4:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a == ADDR_MONITOR) e = mon;
    else if (a <= ADDR_SCRATCH_D) e = scr[a - 1];
    xfer(mk(CTRL_READ, a, 8'h00), 16);
    `CHK(rx[7:0], e)
    `CHK(rx[15:8], stat)
  endtask

  task automatic chk_out;
    `CHK(sel, mon[7:5])
    `CHK(mon_en, mon[7:5] != SEL_OFF)
    `CHK(res_en, mon[4])
    `CHK(sens_int, mon[7:5] == SEL_CURRENT && mon[4])
    `CHK(sens_ext, mon[7:5] == SEL_CURRENT && !mon[4])
    `CHK(io_att, mon[3] && (mon[7:5] == SEL_IO0 || mon[7:5] == SEL_IO1))
    `CHK(miso_oe_n, 1'b1)
  endtask

  initial begin
    void'($urandom(59));
    mon = 8'h00;
    for (int i = 0; i < 4; i++) scr[i] = 8'h00;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    for (int a = 0; a < 6; a++) rd(5'(a));
    chk_out();
    setc(1'b1, 1'b1, 1'b1);
    for (int c = 0; c < 8; c++) begin
      d = {3'(c), 5'($urandom)};
      wr(ADDR_MONITOR, d);
      chk_out();
      rd(ADDR_MONITOR);
    end
    repeat (12) begin
      wr(5'(1 + $urandom % 4), 8'($urandom));
      rd(5'(1 + $urandom % 4));
    end
    xfer(mk(CTRL_WRITE, ADDR_SCRATCH_A, 8'h5a) ^ 16'h0100, 16);
    rd(ADDR_SCRATCH_A);
    xfer(mk(CTRL_WRITE, ADDR_SCRATCH_B, 8'ha5), 15);
    rd(ADDR_SCRATCH_B);
    wr(5'h05, 8'hff);
    rd(5'h05);
    setc(1'b0, 1'b1, 1'b1);
    wr(ADDR_SCRATCH_C, 8'h3c);
    rd(ADDR_SCRATCH_C);
    wr(ADDR_MONITOR, 8'hd0);
    setc(1'b0, 1'b0, 1'b1);
    chk_out();
    wr(ADDR_MONITOR, 8'he0);
    rd(ADDR_MONITOR);
    rd(ADDR_SCRATCH_D);
    setc(1'b0, 1'b1, 1'b1);
    wr(ADDR_MONITOR, 8'h98);
    chk_out();
    setc(1'b0, 1'b1, 1'b0);
    chk_out();
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) scr[i] = 8'h00;
    setc(1'b0, 1'b1, 1'b1);
    for (int a = 1; a < 5; a++) rd(5'(a));
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
